// ==== verilog/bsam_map.svh ====
// constants of the byte strobe address mapper
`ifndef BSAM_MAP_SVH
`define BSAM_MAP_SVH
// =====================================================================
// widths
`define BSAM_ADDR_W 24
`define BSAM_DATA_W 32
`define BSAM_SIZE_W 2
`define BSAM_LANES 4
`define BSAM_CNT_W 8
// fifo entry is write flag, address and write data
`define BSAM_REQ_W (1 + `BSAM_ADDR_W + `BSAM_DATA_W)
`define BSAM_FIFO_DEPTH 8
// =====================================================================
// strobe group address ranges
`define BSAM_GRP_A_LIMIT 24'h80_0000
`define BSAM_GRP_A_ALT_BASE 24'h88_0000
`define BSAM_GRP_B_BASE 24'h90_0000
// =====================================================================
// lane patterns, active low
`define BSAM_LANES_IDLE 4'hF
`define BSAM_LANES_ALL 4'h0
`define BSAM_LANES_LOW_HALF 4'hC
`define BSAM_LANES_HIGH_HALF 4'h3
// =====================================================================
// timing
`define BSAM_CLK_PERIOD_PS 4000
`define BSAM_ACCESS_TIME_PS 10000
`define BSAM_ACCESS_CYCLES \
  ((`BSAM_ACCESS_TIME_PS + `BSAM_CLK_PERIOD_PS - 1) / `BSAM_CLK_PERIOD_PS)
`define BSAM_SYNC_STAGES 2
`endif

// ==== verilog/bsam_pkg.sv ====
// types of the byte strobe address mapper
`include "bsam_map.svh"
package bsam_pkg;
  // =====================================================================
  // enumerations
  typedef enum logic [1:0] {BSAM_SIZE_8, BSAM_SIZE_16, BSAM_SIZE_32} bsam_size_t;
  typedef enum logic [1:0] {BSAM_GRP_NONE, BSAM_GRP_A, BSAM_GRP_B} bsam_grp_t;
  typedef enum logic {BSAM_IDLE, BSAM_ACCESS} bsam_state_t;
  // =====================================================================
  // whole state of the mapper
  typedef struct packed {
    bsam_state_t st;
    logic phase;
    logic [`BSAM_CNT_W-1:0] cnt;
    logic write;
    logic [`BSAM_ADDR_W-1:0] addr;
    logic [`BSAM_DATA_W-1:0] wdata;
    bsam_grp_t grp;
    logic wid16;
    bsam_size_t size;
    logic [`BSAM_DATA_W-1:0] sync1;
    logic [`BSAM_DATA_W-1:0] sync2;
    logic [`BSAM_ADDR_W-1:0] ext_addr;
    logic [`BSAM_LANES-1:0] lanes_a_n;
    logic [`BSAM_LANES-1:0] lanes_b_n;
    logic we_n;
    logic [`BSAM_DATA_W-1:0] dout;
    logic doe_n;
    logic [`BSAM_DATA_W-1:0] rdata;
    logic done;
  } bsam_state_s_t;
endpackage

// ==== verilog/bsam_fifo.sv ====
// request fifo of the byte strobe address mapper
`timescale 1ns/1ps
`default_nettype none
module bsam_fifo #(
  parameter int WIDTH = 57,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  // =====================================================================
  // state
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem; // entries
    logic [AW-1:0] wr; // write index
    logic [AW-1:0] rd; // read index
    logic [AW:0] cnt; // fill level
    logic rdy; // room left
  } bsam_fifo_t;
  bsam_fifo_t s;
  bsam_fifo_t next_s;
  logic push;
  logic pop;

  assign push = in_valid_i && s.rdy;
  assign pop = out_valid_o && out_ready_i;
  assign in_ready_o = s.rdy;
  assign out_valid_o = (s.cnt != '0);
  assign out_data_o = s.mem[s.rd];

  // next state: store, advance indices, track level
  always_comb
  begin
    next_s = s;
    if (push)
    begin
      next_s.mem[s.wr] = in_data_i;
      next_s.wr = (s.wr == AW'(DEPTH - 1)) ? '0 : s.wr + 1'b1;
    end
    if (pop)
    begin
      next_s.rd = (s.rd == AW'(DEPTH - 1)) ? '0 : s.rd + 1'b1;
    end
    if (push && !pop)
    begin
      next_s.cnt = s.cnt + 1'b1;
    end
    else if (pop && !push)
    begin
      next_s.cnt = s.cnt - 1'b1;
    end
    next_s.rdy = (next_s.cnt != (AW+1)'(DEPTH));
  end

  // register, synchronous active low reset
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      s <= '0;
      s.rdy <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end
endmodule
`default_nettype wire

// ==== verilog/bsam_mapper.sv ====
// byte strobe address mapper for 32- and 16-bit asynchronous sram banks
// Operation
// - byte size shifts address two, replicates top
// - byte size strobes one lane by bits 1:0 on a wide bank, of lanes 1:0 by bit 0 on a narrow one
// - half size shifts address one, replicates top
// - half size strobes lane pair by bit 0 on a wide bank, low pair on a narrow one
// - word size passes address unchanged
// - word size strobes all four lanes of a wide bank, lanes 1:0 of a narrow one
// - narrow bank: top strobe is lowest address
// - every bank width completes any size access
// - each group uses its own width, size
`timescale 1ns/1ps
`default_nettype none
`include "bsam_map.svh"
module bsam_mapper #(
  parameter int unsigned ACC_CYCLES = `BSAM_ACCESS_CYCLES,
  parameter int FIFO_DEPTH = `BSAM_FIFO_DEPTH
) (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic REQ_VALID_I,
  output logic REQ_READY_O,
  input wire logic REQ_WRITE_I,
  input wire logic [`BSAM_ADDR_W-1:0] REQ_ADDR_I,
  input wire logic [`BSAM_DATA_W-1:0] REQ_WDATA_I,
  input wire logic CFG_A_WIDTH16_I,
  input wire logic [`BSAM_SIZE_W-1:0] CFG_A_SIZE_I,
  input wire logic CFG_B_WIDTH16_I,
  input wire logic [`BSAM_SIZE_W-1:0] CFG_B_SIZE_I,
  output logic [`BSAM_ADDR_W-1:0] EXT_ADDR_O,
  output logic [`BSAM_LANES-1:0] BANK_SELECT_GROUP_A_LANE_N_O,
  output logic [`BSAM_LANES-1:0] BANK_SELECT_GROUP_B_LANE_N_O,
  output logic EXT_WE_N_O,
  output logic [`BSAM_DATA_W-1:0] EXT_DATA_O,
  output logic EXT_DATA_OE_N_O,
  input wire logic [`BSAM_DATA_W-1:0] EXT_DATA_I,
  output logic DONE_O,
  output logic [`BSAM_DATA_W-1:0] RD_DATA_O
);
  // =====================================================================
  // state and fifo wires
  bsam_pkg::bsam_state_s_t s; // registered state
  bsam_pkg::bsam_state_s_t next_s; // next state
  logic fifo_valid; // request waiting
  logic [`BSAM_REQ_W-1:0] fifo_data; // head request
  logic take; // head taken this cycle
  localparam logic [`BSAM_CNT_W-1:0] LAST_CNT = `BSAM_CNT_W'(ACC_CYCLES + `BSAM_SYNC_STAGES - 1);

  assign take = fifo_valid && (s.st == bsam_pkg::BSAM_IDLE);

  // =====================================================================
  // request buffer
  bsam_fifo #(
    .WIDTH(`BSAM_REQ_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .in_valid_i(REQ_VALID_I),
    .in_data_i({REQ_WRITE_I, REQ_ADDR_I, REQ_WDATA_I}),
    .in_ready_o(REQ_READY_O),
    .out_valid_o(fifo_valid),
    .out_data_o(fifo_data),
    .out_ready_i(s.st == bsam_pkg::BSAM_IDLE)
  );

  // =====================================================================
  // helpers
  // address range to strobe group
  function automatic bsam_pkg::bsam_grp_t grp_of(input logic [`BSAM_ADDR_W-1:0] a);
    if (a < `BSAM_GRP_A_LIMIT)
      return bsam_pkg::BSAM_GRP_A;
    else if (a >= `BSAM_GRP_B_BASE)
      return bsam_pkg::BSAM_GRP_B;
    else if (a >= `BSAM_GRP_A_ALT_BASE)
      return bsam_pkg::BSAM_GRP_A;
    else
      return bsam_pkg::BSAM_GRP_NONE;
  endfunction

  // pick the read bytes out of the sampled pins, zero filled
  function automatic logic [`BSAM_DATA_W-1:0] rd_pick(input bsam_pkg::bsam_state_s_t c);
    logic [`BSAM_DATA_W-1:0] r;
    r = c.rdata;
    case (c.size)
      bsam_pkg::BSAM_SIZE_8:
        if (c.wid16)
          r = {24'h00_0000, c.addr[0] ? c.sync2[15:8] : c.sync2[7:0]};
        else
          r = {24'h00_0000, c.sync2[8*c.addr[1:0] +: 8]};
      bsam_pkg::BSAM_SIZE_16:
        if (c.wid16)
          r = {16'h0000, c.sync2[15:0]};
        else
          r = {16'h0000, c.addr[0] ? c.sync2[31:16] : c.sync2[15:0]};
      default:
        if (!c.wid16)
          r = c.sync2;
        else if (c.phase)
          r[31:16] = c.sync2[15:0];
        else
          r[15:0] = c.sync2[15:0];
    endcase
    return r;
  endfunction

  // =====================================================================
  // next state
  always_comb
  begin
    logic [`BSAM_LANES-1:0] lanes; // lane enables of the access
    logic am1; // extra lowest address of a narrow bank
    lanes = `BSAM_LANES_IDLE;
    am1 = 1'b0;
    next_s = s;
    next_s.done = 1'b0;
    // data pins pass two flops before use
    next_s.sync1 = EXT_DATA_I;
    next_s.sync2 = s.sync1;
    case (s.st)
      bsam_pkg::BSAM_IDLE:
      begin
        // take the head request
        if (take)
        begin
          next_s.st = bsam_pkg::BSAM_ACCESS;
          next_s.phase = 1'b0;
          next_s.cnt = '0;
          {next_s.write, next_s.addr, next_s.wdata} = fifo_data;
          next_s.grp = grp_of(fifo_data[`BSAM_DATA_W +: `BSAM_ADDR_W]);
          if (next_s.grp == bsam_pkg::BSAM_GRP_B)
          begin
            next_s.wid16 = CFG_B_WIDTH16_I;
            next_s.size = bsam_pkg::bsam_size_t'(CFG_B_SIZE_I);
          end
          else
          begin
            next_s.wid16 = CFG_A_WIDTH16_I;
            next_s.size = bsam_pkg::bsam_size_t'(CFG_A_SIZE_I);
          end
        end
      end
      bsam_pkg::BSAM_ACCESS:
      begin
        next_s.cnt = s.cnt + 1'b1;
        // end of a bus cycle: sample, then second half or finish
        if (s.cnt == LAST_CNT)
        begin
          if (!s.write)
            next_s.rdata = rd_pick(s);
          // word on narrow bank takes two bus cycles
          if (s.wid16 && (s.size != bsam_pkg::BSAM_SIZE_8) &&
              (s.size != bsam_pkg::BSAM_SIZE_16) && !s.phase)
          begin
            next_s.phase = 1'b1;
            next_s.cnt = '0;
          end
          else
          begin
            next_s.st = bsam_pkg::BSAM_IDLE;
            next_s.done = 1'b1;
          end
        end
      end
      default:
      begin
        next_s.st = bsam_pkg::BSAM_IDLE;
      end
    endcase
    // pin values follow the next state
    if (next_s.st == bsam_pkg::BSAM_ACCESS)
    begin
      case (next_s.size)
        bsam_pkg::BSAM_SIZE_8:
        begin
          next_s.ext_addr = {next_s.addr[23], next_s.addr[23], next_s.addr[23:2]};
          am1 = next_s.addr[1];
          lanes = ~(4'h1 << next_s.addr[1:0]);
          next_s.dout = {4{next_s.wdata[7:0]}};
          if (next_s.wid16)
            lanes[1:0] = next_s.addr[0] ? 2'h1 : 2'h2;
        end
        bsam_pkg::BSAM_SIZE_16:
        begin
          next_s.ext_addr = {next_s.addr[23], next_s.addr[23:1]};
          am1 = next_s.addr[0];
          lanes = next_s.addr[0] ? `BSAM_LANES_HIGH_HALF : `BSAM_LANES_LOW_HALF;
          next_s.dout = {2{next_s.wdata[15:0]}};
          if (next_s.wid16)
            lanes = `BSAM_LANES_LOW_HALF;
        end
        default:
        begin
          next_s.ext_addr = next_s.addr;
          am1 = next_s.phase;
          lanes = `BSAM_LANES_ALL;
          next_s.dout = next_s.wdata;
          if (next_s.wid16)
          begin
            lanes = `BSAM_LANES_LOW_HALF;
            next_s.dout = {2{next_s.phase ? next_s.wdata[31:16] : next_s.wdata[15:0]}};
          end
        end
      endcase
      // top strobe carries extra address, lane 2 unused
      if (next_s.wid16)
        lanes[3:2] = {am1, 1'b1};
      next_s.lanes_a_n = (next_s.grp == bsam_pkg::BSAM_GRP_A) ? lanes : `BSAM_LANES_IDLE;
      next_s.lanes_b_n = (next_s.grp == bsam_pkg::BSAM_GRP_B) ? lanes : `BSAM_LANES_IDLE;
      next_s.we_n = !(next_s.write && (next_s.grp != bsam_pkg::BSAM_GRP_NONE));
      next_s.doe_n = !next_s.write;
    end
    else
    begin
      // idle: strobes high, data pins released
      next_s.lanes_a_n = `BSAM_LANES_IDLE;
      next_s.lanes_b_n = `BSAM_LANES_IDLE;
      next_s.we_n = 1'b1;
      next_s.doe_n = 1'b1;
    end
  end

  // register, synchronous active low reset
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      s <= '0;
      s.lanes_a_n <= `BSAM_LANES_IDLE;
      s.lanes_b_n <= `BSAM_LANES_IDLE;
      s.we_n <= 1'b1;
      s.doe_n <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  // outputs straight from the state flops
  assign EXT_ADDR_O = s.ext_addr;
  assign BANK_SELECT_GROUP_A_LANE_N_O = s.lanes_a_n;
  assign BANK_SELECT_GROUP_B_LANE_N_O = s.lanes_b_n;
  assign EXT_WE_N_O = s.we_n;
  assign EXT_DATA_O = s.dout;
  assign EXT_DATA_OE_N_O = s.doe_n;
  assign DONE_O = s.done;
  assign RD_DATA_O = s.rdata;

  // =====================================================================
  // checks
  logic act; // an external group is being strobed
  logic [`BSAM_LANES-1:0] cur_lanes; // lanes of the active group
  assign act = (s.st == bsam_pkg::BSAM_ACCESS) && (s.grp != bsam_pkg::BSAM_GRP_NONE);
  assign cur_lanes = (s.grp == bsam_pkg::BSAM_GRP_B) ? s.lanes_b_n : s.lanes_a_n;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  a_byte_shift: assert property (act && s.size == bsam_pkg::BSAM_SIZE_8 |->
    EXT_ADDR_O == {s.addr[23], s.addr[23], s.addr[23:2]}) else $error("byte address wrong");
  a_byte_lane: assert property (act && !s.wid16 && s.size == bsam_pkg::BSAM_SIZE_8 |->
    cur_lanes == ~(4'h1 << s.addr[1:0])) else $error("byte lane wrong");
  a_half_shift: assert property (act && s.size == bsam_pkg::BSAM_SIZE_16 |->
    EXT_ADDR_O == {s.addr[23], s.addr[23:1]}) else $error("half address wrong");
  a_half_lane: assert property (act && !s.wid16 && s.size == bsam_pkg::BSAM_SIZE_16 |->
    cur_lanes == (s.addr[0] ? 4'h3 : 4'hC)) else $error("half lanes wrong");
  a_word_pass: assert property (act && s.size == bsam_pkg::BSAM_SIZE_32 |->
    EXT_ADDR_O == s.addr) else $error("word address changed");
  a_word_lanes: assert property (act && !s.wid16 && s.size == bsam_pkg::BSAM_SIZE_32 |->
    cur_lanes == 4'h0) else $error("word lanes not all on");
  a_narrow_pins: assert property (act && s.wid16 && s.size == bsam_pkg::BSAM_SIZE_32 |->
    cur_lanes == {s.phase, 3'h4}) else $error("narrow pins wrong");
  a_access_done: assert property (take |-> ##[1:40] DONE_O)
    else $error("access not done");
  a_cfg_select: assert property ($rose(s.st == bsam_pkg::BSAM_ACCESS) &&
    s.grp == bsam_pkg::BSAM_GRP_B |-> s.wid16 == $past(CFG_B_WIDTH16_I))
    else $error("group b config not used");
  a_group_quiet: assert property (!(act && s.grp == bsam_pkg::BSAM_GRP_A) |->
    BANK_SELECT_GROUP_A_LANE_N_O == 4'hF) else $error("idle group strobed");
endmodule
`default_nettype wire

// ==== dv/bsam_sram_model.sv ====
// asynchronous sram banks of both strobe groups, seen at the mapper's pins
`timescale 1ns/1ps
`default_nettype none
module bsam_sram_model (
  input wire logic clk_i,
  input wire logic [23:0] addr_i,
  input wire logic [3:0] lane_a_n_i,
  input wire logic [3:0] lane_b_n_i,
  input wire logic wid_a16_i,
  input wire logic wid_b16_i,
  input wire logic we_n_i,
  input wire logic [31:0] data_i,
  output logic [31:0] data_o
);
  // =====================================================================
  // storage and decode
  // top index bit picks the group's bank
  logic [31:0] mem [0:511];
  // last pin value; released pins show its inverse
  logic [31:0] last = 32'h5A5A_A5A5;
  logic grp_b;
  logic nar;
  logic sel;
  logic [3:0] ln;
  logic [8:0] ix;
  logic [4:0] off;
  // which bank is strobed, and what it drives back
  always_comb
  begin
    grp_b = (lane_a_n_i == 4'hF);
    ln = grp_b ? lane_b_n_i : lane_a_n_i;
    nar = grp_b ? wid_b16_i : wid_a16_i;
    sel = nar ? (ln[1:0] != 2'h3) : (ln != 4'hF);
    ix = {grp_b, addr_i[7:0]};
    off = (nar && ln[3]) ? 5'h10 : 5'h00;
    data_o = ~last;
    if (sel && we_n_i)
      data_o = nar ? {~last[31:16], mem[ix][off +: 16]} : mem[ix];
  end
  // =====================================================================
  // lane-wise write while the write enable is low
  always @(posedge clk_i)
  begin
    last <= data_o;
    if (sel && !we_n_i)
      for (int k = 0; k < 4; k++)
        if (!ln[k] && (k < 2 || !nar))
          mem[ix][8*k + off +: 8] <= data_i[8*k +: 8];
  end
endmodule
`default_nettype wire

// ==== dv/bsam_mapper_tb.sv ====
// self-checking testbench of the byte strobe address mapper
`timescale 1ns/1ps
`default_nettype none
module bsam_mapper_tb;
  // =====================================================================
  // stimulus and observed signals
  logic clk;
  logic rst_n;
  logic vld;
  logic wr;
  logic a16;
  logic b16;
  logic rdy;
  logic we_n;
  logic oe_n;
  logic done;
  logic [1:0] asz;
  logic [1:0] bsz;
  logic [23:0] adr;
  logic [23:0] ext_adr;
  logic [3:0] la;
  logic [3:0] lb;
  logic [31:0] wd;
  logic [31:0] din;
  logic [31:0] dout;
  logic [31:0] rdat;
  int err_total;
  int cmp_count;
  int dcnt;
  bsam_mapper i_dut (.CLK_I(clk), .RST_N_I(rst_n), .REQ_VALID_I(vld), .REQ_READY_O(rdy),
    .REQ_WRITE_I(wr), .REQ_ADDR_I(adr), .REQ_WDATA_I(wd), .CFG_A_WIDTH16_I(a16),
    .CFG_A_SIZE_I(asz), .CFG_B_WIDTH16_I(b16), .CFG_B_SIZE_I(bsz), .EXT_ADDR_O(ext_adr),
    .BANK_SELECT_GROUP_A_LANE_N_O(la), .BANK_SELECT_GROUP_B_LANE_N_O(lb), .EXT_WE_N_O(we_n),
    .EXT_DATA_O(dout), .EXT_DATA_OE_N_O(oe_n), .EXT_DATA_I(din), .DONE_O(done),
    .RD_DATA_O(rdat));
  bsam_sram_model i_mem (.clk_i(clk), .addr_i(ext_adr), .lane_a_n_i(la), .lane_b_n_i(lb),
    .wid_a16_i(a16), .wid_b16_i(b16), .we_n_i(we_n), .data_i(dout), .data_o(din));
  // =====================================================================
  // clock, completion counter, watchdog
  initial
  begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
    if (done === 1'b1)
      dcnt <= dcnt + 1;
  // about sixty accesses of under twenty cycles each; wide margin
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    close_out;
  end
  // =====================================================================
  // shared tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    cmp_count++;
    if (g !== e)
    begin
      err_total++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask
  // one access; captures first and last active lanes of the watched group
  task automatic acc(input logic w, input logic [23:0] a, input logic [31:0] d,
    input logic b, output logic [23:0] ea, output logic [3:0] lf, output logic [3:0] ll,
    output logic [31:0] rd);
    logic [3:0] gl;
    logic bad;
    int n;
    lf = 4'hF;
    ll = 4'hF;
    ea = '0;
    bad = 0;
    n = 0;
    @(negedge clk);
    // hold off while the buffer is full
    while (rdy !== 1'b1)
      @(negedge clk);
    vld = 1;
    wr = w;
    adr = a;
    wd = d;
    @(negedge clk);
    vld = 0;
    while (done !== 1'b1 && n < 60)
    begin
      gl = b ? lb : la;
      if (gl !== 4'hF)
      begin
        if (lf === 4'hF)
        begin
          ea = ext_adr;
          lf = gl;
          chk({we_n, oe_n}, w ? 32'h0000_0000 : 32'h0000_0003, "direction");
        end
        ll = gl;
      end
      if ((b ? la : lb) !== 4'hF)
        bad = 1;
      @(negedge clk);
      n++;
    end
    rd = rdat;
    chk(n < 60, 1, "done pulse");
    chk(bad, 0, "other group strobed");
  endtask
  // write then read back one place, checking pins both times
  task automatic wr_rd(input logic [23:0] a, input logic [31:0] d, input logic b,
    input logic [23:0] ea, input logic [3:0] lf, input logic [3:0] ll, input logic [31:0] er);
    logic [23:0] ga;
    logic [3:0] gf;
    logic [3:0] gl;
    logic [31:0] rd;
    for (int r = 0; r < 2; r++)
    begin
      acc(r == 0, a, d, b, ga, gf, gl, rd);
      chk(ga, ea, "address");
      chk(gf, lf, "first lanes");
      chk(gl, ll, "last lanes");
    end
    chk(rd, er, "read data");
  endtask
  // =====================================================================
  // scenarios
  task automatic t_byte;
    logic [23:0] e;
    logic [3:0] m;
    bsz = bsam_pkg::BSAM_SIZE_8;
    for (int i = 0; i < 5; i++)
    begin
      e = (i < 4) ? 24'hE4_1000 : 24'hE4_1001;
      m = ~(4'h1 << (i % 4));
      wr_rd(24'h90_4000 + i, 32'h0000_00A0 + i, 1, e, m, m, 32'h0000_00A0 + i);
    end
    $display("test byte done");
  endtask
  task automatic t_half;
    logic [23:0] e;
    logic [3:0] m;
    bsz = bsam_pkg::BSAM_SIZE_16;
    for (int i = 0; i < 4; i++)
    begin
      e = 24'hC8_2000 + i / 2;
      m = (i % 2) ? 4'h3 : 4'hC;
      wr_rd(24'h90_4000 + i, 32'h0000_B000 + i, 1, e, m, m, 32'h0000_B000 + i);
    end
    $display("test half done");
  endtask
  task automatic t_word;
    // size code 3 acts as word; second range of group a
    asz = 2'h3;
    bsz = bsam_pkg::BSAM_SIZE_32;
    wr_rd(24'h88_0005, 32'h0F0F_1234, 0, 24'h88_0005, 4'h0, 4'h0, 32'h0F0F_1234);
    asz = bsam_pkg::BSAM_SIZE_32;
    wr_rd(24'h00_4003, 32'h1234_5678, 0, 24'h00_4003, 4'h0, 4'h0, 32'h1234_5678);
    wr_rd(24'h90_4004, 32'h89AB_CDEF, 1, 24'h90_4004, 4'h0, 4'h0, 32'h89AB_CDEF);
    $display("test word done");
  endtask
  task automatic t_narrow;
    a16 = 1;
    bsz = bsam_pkg::BSAM_SIZE_8;
    wr_rd(24'h00_4001, 32'hCAFE_F00D, 0, 24'h00_4001, 4'h4, 4'hC, 32'hCAFE_F00D);
    asz = bsam_pkg::BSAM_SIZE_8;
    wr_rd(24'h00_4002, 32'h0000_005A, 0, 24'h00_1000, 4'hE, 4'hE, 32'h0000_005A);
    wr_rd(24'h00_4001, 32'h0000_0033, 0, 24'h00_1000, 4'h5, 4'h5, 32'h0000_0033);
    asz = bsam_pkg::BSAM_SIZE_16;
    wr_rd(24'h00_4001, 32'h0000_BEEF, 0, 24'h00_2000, 4'hC, 4'hC, 32'h0000_BEEF);
    wr_rd(24'h90_4001, 32'h0000_0077, 1, 24'hE4_1000, 4'hD, 4'hD, 32'h0000_0077);
    // narrow bank on the second group too
    b16 = 1;
    bsz = bsam_pkg::BSAM_SIZE_16;
    wr_rd(24'h90_4002, 32'h0000_1357, 1, 24'hC8_2001, 4'h4, 4'h4, 32'h0000_1357);
    $display("test narrow done");
  endtask
  task automatic t_fifo;
    logic [23:0] ga;
    logic [3:0] gf;
    logic [3:0] gl;
    logic [31:0] rd;
    logic r;
    logic full;
    int n;
    int base;
    a16 = 0;
    asz = bsam_pkg::BSAM_SIZE_32;
    full = 0;
    n = 0;
    base = dcnt;
    acc(1, 24'h80_0010, 32'h0000_0001, 0, ga, gf, gl, rd);
    chk(gf, 4'hF, "unmapped strobes");
    @(negedge clk);
    vld = 1;
    wr = 1;
    base = dcnt;
    // offer back to back for fourteen cycles, noting whether the buffer refuses
    for (int k = 0; k < 14; k++)
    begin
      adr = 24'h00_4100 + n;
      wd = 32'h5500_0000 + n;
      r = rdy;
      @(negedge clk);
      if (r)
        n++;
      else
        full = 1;
    end
    vld = 0;
    for (int k = 0; k < 400 && dcnt < base + n; k++)
      @(negedge clk);
    chk(full, 1, "fifo refused");
    chk(dcnt - base, n, "done count");
    chk(rdy, 1, "fifo drained");
    for (int k = 0; k < n; k++)
    begin
      acc(0, 24'h00_4100 + k, 32'h0000_0000, 0, ga, gf, gl, rd);
      chk(rd, 32'h5500_0000 + k, "queued data");
    end
    $display("test fifo done");
  endtask
  // =====================================================================
  // verdict
  task close_out;
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    rst_n = 0;
    vld = 0;
    wr = 0;
    adr = '0;
    wd = '0;
    a16 = 0;
    b16 = 0;
    asz = bsam_pkg::BSAM_SIZE_32;
    bsz = bsam_pkg::BSAM_SIZE_32;
    repeat (20) @(negedge clk);
    rst_n = 1;
    chk({la, lb}, 32'h0000_00FF, "idle lanes");
    t_byte;
    t_half;
    t_word;
    t_narrow;
    t_fifo;
    close_out;
  end
endmodule
`default_nettype wire
